// File: common/otc_defs.vh
`ifndef OTC_DEFS_VH
`define OTC_DEFS_VH

// ==========================================================
// register offsets (byte addresses on the apb bus)
// ==========================================================
`define OTC_OFS_CTRL      8'h00
`define OTC_OFS_STATUS    8'h04

// ==========================================================
// control register fields
// ==========================================================
`define OTC_CTRL_CWL_LSB  0
`define OTC_CTRL_AL_LSB   4
`define OTC_CTRL_NOM_LSB  9
`define OTC_CTRL_WR_LSB   12
`define OTC_CTRL_BL_LSB   14
`define OTC_CTRL_DLL_BIT  16
`define OTC_CTRL_SR_BIT   17
`define OTC_CTRL_RST      32'h00010005

// burst length modes held in the bl field
`define OTC_BL_FIX8       2'h0
`define OTC_BL_OTF        2'h1
`define OTC_BL_FIX4       2'h2

// ==========================================================
// status register fields
// ==========================================================
`define OTC_ST_RTT_EN     0
`define OTC_ST_USE_WR     1
`define OTC_ST_VAL_LSB    2
`define OTC_ST_ODT        5
`define OTC_ST_DYN        6
`define OTC_ST_HOLD_ERR   7
`define OTC_ST_RD_ERR     8

// ==========================================================
// timing counts in ck cycles, delay line depth and pin width
// ==========================================================
`define OTC_LAT_SUB       6'h02
`define OTC_ODTH4         3'h4
`define OTC_ODTH8         3'h6
`define OTC_CWN4_ADD      6'h04
`define OTC_CWN8_ADD      6'h06
`define OTC_DEPTH         32
`define OTC_LAT_MAX       6'h1f
`define OTC_PIN_W         5

`endif

// File: core/otc_sync.v
`include "otc_defs.vh"

// ==========================================================
// pin synchroniser: three flops, level taken when 2nd and 3rd agree
// ==========================================================
module otc_sync #(
    parameter W = `OTC_PIN_W
) (
    input  wire         pclk,
    input  wire         presetn,
    input  wire [W-1:0] pin_in,
    output reg  [W-1:0] pin_q
);

    reg [W-1:0] s1_q;   // metastability catcher, read only by s2_q
    reg [W-1:0] s2_q;   // second stage
    reg [W-1:0] s3_q;   // third stage, compared with second

    // a bit moves only when the two later stages agree, which filters a
    // single-cycle glitch at the cost of one extra cycle of latency
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_q  <= {W{1'b0}};
            s2_q  <= {W{1'b0}};
            s3_q  <= {W{1'b0}};
            pin_q <= {W{1'b0}};
        end else begin
            s1_q  <= pin_in;
            s2_q  <= s1_q;
            s3_q  <= s2_q;
            pin_q <= (s2_q & ~(s2_q ^ s3_q)) | (pin_q & (s2_q ^ s3_q));
        end
    end

endmodule

// File: core/otc_dline.v
`include "otc_defs.vh"

// ==========================================================
// delay line counted in ck rising edges
// ==========================================================
module otc_dline (
    input  wire                   pclk,
    input  wire                   presetn,
    input  wire                   step,
    input  wire                   flush,
    input  wire                   bit_in,
    output reg  [`OTC_DEPTH-1:0]  line_q
);

    // index 0 holds the value taken at the latest ck edge; index n holds
    // the value taken n ck edges earlier, so any latency is a plain tap
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            line_q <= {`OTC_DEPTH{1'b0}};
        end else if (flush) begin
            line_q <= {`OTC_DEPTH{1'b0}};
        end else if (step) begin
            line_q <= {line_q[`OTC_DEPTH-2:0], bit_in};
        end
    end

endmodule

// File: core/otc_odt_ctrl.v
`include "otc_defs.vh"

module otc_odt_ctrl (
    input  wire        pclk,
    input  wire        presetn,
    // apb slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    // dram pins and read path, all from outside pclk's domain
    input  wire        ck,
    input  wire        odt,
    input  wire        wr_cmd,
    input  wire        wr_bc4,
    input  wire        rd_drive,
    // termination switch
    output reg         rtt_en,
    output reg         rtt_use_wr,
    output reg  [2:0]  rtt_value
);

    // ==========================================================
    // helpers
    // ==========================================================

    // or of the taps lo .. hi-1, the span in which a write holds rtt_wr
    function win_or;
        input [`OTC_DEPTH-1:0] v;
        input [5:0]            lo;
        input [5:0]            hi;
        integer                i;
        begin
            win_or = 1'b0;
            for (i = 0; i < `OTC_DEPTH; i = i + 1) begin
                if ((i >= lo) && (i < hi)) begin
                    win_or = win_or | v[i];
                end
            end
        end
    endfunction

    // keeps a latency inside the delay line
    function [5:0] clip;
        input [6:0] x;
        begin
            if (x > {1'b0, `OTC_LAT_MAX}) begin
                clip = `OTC_LAT_MAX;
            end else begin
                clip = x[5:0];
            end
        end
    endfunction

    // ==========================================================
    // pin synchronisation and ck edge detect
    // ==========================================================
    wire [`OTC_PIN_W-1:0] pin_s;      // synchronised pins
    reg                   ck_prev_q;  // last stable ck level
    wire                  ck_s;       // stable ck
    wire                  odt_s;      // stable odt
    wire                  wr_s;       // stable write command
    wire                  bc4_s;      // stable burst chop select
    wire                  rd_s;       // stable read-drive level
    wire                  ck_rise;    // one pclk per ck rising edge

    otc_sync #(
        .W (`OTC_PIN_W)
    ) u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .pin_in  ({rd_drive, wr_bc4, wr_cmd, odt, ck}),
        .pin_q   (pin_s)
    );

    assign ck_s  = pin_s[0];
    assign odt_s = pin_s[1];
    assign wr_s  = pin_s[2];
    assign bc4_s = pin_s[3];
    assign rd_s  = pin_s[4];

    // ck edges are found from the filtered level, so a noisy ck cannot
    // produce two steps of the pipelines per period
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ck_prev_q <= 1'b0;
        end else begin
            ck_prev_q <= ck_s;
        end
    end

    assign ck_rise = ck_s & ~ck_prev_q;

    // ==========================================================
    // register file
    // ==========================================================
    reg  [31:0] ctrl_q;      // latencies, strengths, modes
    reg         hold_err_q;  // odt dropped before hold was met
    reg         rd_err_q;    // read drive seen while odt path was on
    wire        acc;         // access phase, answer not yet given
    wire        take;        // edge at which the transfer completes
    wire        hit_ctrl;    // control register selected
    wire        hit_stat;    // status register selected
    wire        w1c_hold;    // software clear of hold error
    wire        w1c_rd;      // software clear of read error
    reg  [31:0] status;      // status word as read

    assign acc      = psel & penable & ~pready;
    assign take     = psel & penable & pready;
    assign hit_ctrl = (paddr == `OTC_OFS_CTRL);
    assign hit_stat = (paddr == `OTC_OFS_STATUS);
    assign w1c_hold = take & pwrite & hit_stat & pwdata[`OTC_ST_HOLD_ERR];
    assign w1c_rd   = take & pwrite & hit_stat & pwdata[`OTC_ST_RD_ERR];

    // one wait state: pready is set at the edge ending the first access
    // cycle and the transfer completes at the following edge
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end else if (acc) begin
            pready  <= 1'b1;
            pslverr <= ~(hit_ctrl | hit_stat);
            if (pwrite) begin
                prdata <= 32'h00000000;
            end else if (hit_ctrl) begin
                prdata <= ctrl_q;
            end else if (hit_stat) begin
                prdata <= status;
            end else begin
                prdata <= 32'h00000000;
            end
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end
    end

    // control register, written only at the completing edge
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= `OTC_CTRL_RST;
        end else if (take & pwrite & hit_ctrl) begin
            ctrl_q <= {14'h0000, pwdata[17:0]};
        end
    end

    // ==========================================================
    // configuration decode
    // ==========================================================
    wire [3:0] cwl;       // cas write latency
    wire [4:0] al;        // additive latency
    wire [2:0] nom;       // nominal strength code
    wire [1:0] wrs;       // write strength code
    wire [1:0] bl_mode;   // fixed bl8, on the fly, fixed bc4
    wire       dll_on;    // dll enabled and locked
    wire       self_ref;  // self-refresh state
    wire       odt_on;    // termination feature enabled at all
    wire       dyn_on;    // dynamic odt enabled
    wire       active;    // odt pin is honoured
    wire [5:0] lat;       // odtlon = odtloff = odtlcnw
    wire [5:0] cwn4;      // return to nominal after bc4 write
    wire [5:0] cwn8;      // return to nominal after bl8 write
    wire       wr_is4;    // this write is a burst chop

    assign cwl      = ctrl_q[`OTC_CTRL_CWL_LSB +: 4];
    assign al       = ctrl_q[`OTC_CTRL_AL_LSB +: 5];
    assign nom      = ctrl_q[`OTC_CTRL_NOM_LSB +: 3];
    assign wrs      = ctrl_q[`OTC_CTRL_WR_LSB +: 2];
    assign bl_mode  = ctrl_q[`OTC_CTRL_BL_LSB +: 2];
    assign dll_on   = ctrl_q[`OTC_CTRL_DLL_BIT];
    assign self_ref = ctrl_q[`OTC_CTRL_SR_BIT];

    assign odt_on = (nom != 3'h0) | (wrs != 2'h0);
    assign dyn_on = (wrs != 2'h0);
    // synchronous timing only with dll locked; dll-off makes the block
    // ignore the odt pin and keep termination disabled
    assign active = odt_on & dll_on & ~self_ref;

    // latency includes al, so the internal odt is posted by al
    assign lat  = clip({3'h0, cwl} + {2'h0, al} - {1'b0, `OTC_LAT_SUB});
    assign cwn4 = clip({1'b0, lat} + {1'b0, `OTC_CWN4_ADD});
    assign cwn8 = clip({1'b0, lat} + {1'b0, `OTC_CWN8_ADD});

    // burst chop from the mode field, or from the command when on the fly
    assign wr_is4 = (bl_mode == `OTC_BL_FIX4) | ((bl_mode == `OTC_BL_OTF) & bc4_s);

    // ==========================================================
    // latency pipelines
    // ==========================================================
    reg  [31:0]            cfg_prev_q;  // config seen last cycle
    wire                   cfg_chg;     // cwl, al, strength or bl fields moved
    wire [`OTC_DEPTH-1:0]  odt_line;    // sampled odt history
    wire [`OTC_DEPTH-1:0]  w4_line;     // bc4 write history
    wire [`OTC_DEPTH-1:0]  w8_line;     // bl8 write history

    // a latency change empties the pipes: stale bits at new taps would
    // switch termination at times nobody asked for
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_prev_q <= `OTC_CTRL_RST;
        end else begin
            cfg_prev_q <= ctrl_q;
        end
    end

    assign cfg_chg = (cfg_prev_q[15:0] != ctrl_q[15:0]);

    otc_dline u_odt_line (
        .pclk    (pclk),
        .presetn (presetn),
        .step    (ck_rise),
        .flush   (cfg_chg),
        .bit_in  (odt_s & active),
        .line_q  (odt_line)
    );

    otc_dline u_w4_line (
        .pclk    (pclk),
        .presetn (presetn),
        .step    (ck_rise),
        .flush   (cfg_chg),
        .bit_in  (wr_s & wr_is4 & dyn_on & active),
        .line_q  (w4_line)
    );

    otc_dline u_w8_line (
        .pclk    (pclk),
        .presetn (presetn),
        .step    (ck_rise),
        .flush   (cfg_chg),
        .bit_in  (wr_s & ~wr_is4 & dyn_on & active),
        .line_q  (w8_line)
    );

    // ==========================================================
    // termination outputs
    // ==========================================================
    reg       en_d;     // next termination on
    reg       use_wr_d; // next strength select
    reg [2:0] val_d;    // next strength code

    // strength and on/off are computed apart: a write only changes the
    // strength; the odt pin decides whether termination is on, a read drive forces it off
    always @* begin
        en_d     = odt_line[lat[4:0]] & active;
        use_wr_d = win_or(w4_line, lat, cwn4)
                 | win_or(w8_line, lat, cwn8);
        if (rd_s) begin
            en_d = 1'b0;
        end
        if (!use_wr_d) begin
            val_d = nom;
        end else begin
            val_d = {1'b0, wrs};
        end
        if (!en_d) begin
            val_d = 3'h0;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rtt_en     <= 1'b0;
            rtt_use_wr <= 1'b0;
            rtt_value  <= 3'h0;
        end else begin
            rtt_en     <= en_d;
            rtt_use_wr <= use_wr_d & en_d;
            rtt_value  <= val_d;
        end
    end

    // ==========================================================
    // odt hold monitor
    // ==========================================================
    reg  [2:0] hold_q;    // ck edges left before odt may drop
    reg        odt_reg_q; // odt level taken at last ck edge
    reg  [2:0] hold_d;    // next hold count
    wire       set_hold;  // odt registered low too early
    wire       set_rd;    // read drive while odt still high

    // the device cannot enforce the controller's hold times; it flags a
    // breach so software can see it, counting from both the odt rise
    // and any write taken with odt high, whichever ends later
    always @* begin
        hold_d = hold_q;
        if (ck_rise) begin
            if (hold_q != 3'h0) begin
                hold_d = hold_q - 3'h1;
            end
            if (odt_s & ~odt_reg_q & (hold_d < `OTC_ODTH4)) begin
                hold_d = `OTC_ODTH4;
            end
            if (odt_s & wr_s) begin
                if (wr_is4 & (hold_d < `OTC_ODTH4)) begin
                    hold_d = `OTC_ODTH4;
                end else if (~wr_is4 & (hold_d < `OTC_ODTH8)) begin
                    hold_d = `OTC_ODTH8;
                end
            end
        end
    end

    assign set_hold = ck_rise & ~odt_s & odt_reg_q & (hold_q > 3'h1) & active;
    assign set_rd   = rd_s & odt_s & active;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold_q    <= 3'h0;
            odt_reg_q <= 1'b0;
        end else begin
            hold_q <= hold_d;
            if (ck_rise) begin
                odt_reg_q <= odt_s;
            end
        end
    end

    // sticky error flags; a new event beats a same-cycle clear
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold_err_q <= 1'b0;
            rd_err_q   <= 1'b0;
        end else begin
            hold_err_q <= set_hold | (hold_err_q & ~w1c_hold);
            rd_err_q   <= set_rd | (rd_err_q & ~w1c_rd);
        end
    end

    // ==========================================================
    // status word
    // ==========================================================
    always @* begin
        status                                 = 32'h00000000;
        status[`OTC_ST_RTT_EN]                 = rtt_en;
        status[`OTC_ST_USE_WR]                 = rtt_use_wr;
        status[`OTC_ST_VAL_LSB +: 3]           = rtt_value;
        status[`OTC_ST_ODT]                    = odt_reg_q;
        status[`OTC_ST_DYN]                    = dyn_on;
        status[`OTC_ST_HOLD_ERR]               = hold_err_q;
        status[`OTC_ST_RD_ERR]                 = rd_err_q;
    end

endmodule

// File: testbench/otc_ctl_model.sv
// ==========
// far-side controller: drives ck and the odt and write pins
// ==========
module otc_ctl_model (
    output logic ck,
    output logic odt,
    output logic wr_cmd,
    output logic wr_bc4
);
    timeunit 1ns;
    timeprecision 100ps;

    // idle levels: odt low keeps termination off while nothing is set up
    initial begin
        ck = 1'b0;
        odt = 1'b0;
        wr_cmd = 1'b0;
        wr_bc4 = 1'b0;
    end

    // the dram clock runs free, as the controller must keep it stable
    always #62.5 ck = ~ck;

    // pins change on the falling edge so they stand still across the
    // rising edge that registers them; hold lengths come from the caller
    task automatic pins(input logic o, input logic w, input logic b);
        @(negedge ck);
        odt = o;
        wr_cmd = w;
        wr_bc4 = b;
    endtask
endmodule

// File: testbench/otc_odt_ctrl_asserts.sv
// ==========
// port checker for the termination block
// ==========
module otc_odt_ctrl_chk (
    input wire        pclk,
    input wire        presetn,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [7:0]  paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire        pready,
    input wire        pslverr,
    input wire        ck,
    input wire        odt,
    input wire        wr_cmd,
    input wire        wr_bc4,
    input wire        rd_drive,
    input wire        rtt_en,
    input wire        rtt_use_wr,
    input wire [2:0]  rtt_value
);
    timeunit 1ns;
    timeprecision 100ps;

    // ==========
    // control mirror, rebuilt from finished apb writes
    logic [31:0] ctrl_q; // last control word written
    logic [2:0]  calm_q; // cycles since that write, saturating
    wire         hit_w  = psel && penable && pready && pwrite && (paddr == 8'h00);
    wire         off_w  = !ctrl_q[16] || ctrl_q[17] || (ctrl_q[13:9] == 5'h0);
    wire         calm_w = (calm_q == 3'h7);

    // codes are only compared once a write has had time to settle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= 32'h00010005;
            calm_q <= 3'h0;
        end else if (hit_w) begin
            ctrl_q <= pwdata;
            calm_q <= 3'h0;
        end else if (!calm_w) begin
            calm_q <= calm_q + 3'h1;
        end
    end

    // ==========
    // properties
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_setup;
        psel && !penable ##1 psel && penable;
    endsequence
    sequence s_answer;
        !pready ##1 pready;
    endsequence

    AST_APB_WAIT: assert property (s_setup |-> s_answer)
        else $error("apb answer not after one wait state");
    AST_PREADY_PULSE: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    AST_SLVERR: assert property (pready |-> pslverr == (paddr != 8'h00 && paddr != 8'h04))
        else $error("pslverr does not match address map");
    AST_ERR_ZERO: assert property (pready && pslverr |-> prdata == 32'h0)
        else $error("refused read returns data");
    AST_CTRL_READ: assert property (pready && !pwrite && paddr == 8'h00 |-> prdata == (ctrl_q & 32'h0003ffff))
        else $error("control read back differs");
    // rd_drive crosses three sync flops, an agreement stage and the output
    // flop, so termination must be off once it has stood six samples
    AST_READ_OFF: assert property (rd_drive [*6] |-> !rtt_en)
        else $error("termination on while driving read data");
    AST_OFF_QUIET: assert property (!rtt_en |-> !rtt_use_wr && rtt_value == 3'h0)
        else $error("strength shown while termination off");
    AST_IGNORED: assert property (off_w && $past(off_w, 3) |-> !rtt_en)
        else $error("termination on while odt must be ignored");
    AST_NOM_CODE: assert property (rtt_en && !rtt_use_wr && calm_w |-> rtt_value == ctrl_q[11:9])
        else $error("nominal strength code wrong");
    AST_WR_CODE: assert property (rtt_use_wr && calm_w |-> rtt_value == {1'b0, ctrl_q[13:12]} && ctrl_q[13:12] != 2'h0)
        else $error("write strength code wrong");
    COV_WR: cover property (rtt_use_wr);
endmodule

bind otc_odt_ctrl otc_odt_ctrl_chk u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ck(ck), .odt(odt), .wr_cmd(wr_cmd), .wr_bc4(wr_bc4), .rd_drive(rd_drive),
    .rtt_en(rtt_en), .rtt_use_wr(rtt_use_wr), .rtt_value(rtt_value)
);

// File: testbench/testbench.sv
`include "otc_defs.vh"

module testbench;
    timeunit 1ns;
    timeprecision 100ps;

    // ==========
    // signals
    logic        pclk, presetn, psel, penable, pwrite, rd_drive, er;
    logic [7:0]  paddr;
    logic [31:0] pwdata, rd;
    wire  [31:0] prdata;
    wire         pready, pslverr, ck, odt, wr_cmd, wr_bc4, rtt_en, rtt_use_wr;
    wire  [2:0]  rtt_value;
    int          err_count, comparisons, cycles;

    otc_odt_ctrl uut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ck(ck), .odt(odt), .wr_cmd(wr_cmd), .wr_bc4(wr_bc4), .rd_drive(rd_drive),
        .rtt_en(rtt_en), .rtt_use_wr(rtt_use_wr), .rtt_value(rtt_value)
    );
    otc_ctl_model ctl (.ck(ck), .odt(odt), .wr_cmd(wr_cmd), .wr_bc4(wr_bc4));

    always #5 pclk = ~pclk;

    // ==========
    // helpers
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        comparisons++;
        if (s !== e) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic close_out;
        $display("comparisons %0d errors %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // hang guard: the whole run needs only a few thousand cycles
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            err_count++;
            close_out();
        end
    end

    // one apb transfer; no latency assumed, the wait ends on pready
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // n ck rises, then 8 pclk so the sampled rise has fully landed
    task automatic skip_ck(input int n);
        repeat (n) @(posedge ck);
        repeat (8) @(posedge pclk);
    endtask

    function automatic logic [31:0] cw(input logic [3:0] c, input logic [4:0] a,
                                       input logic [2:0] n, input logic [1:0] w, input logic [1:0] b);
        return {15'h0, 1'b1, b, w, n, a, c};
    endfunction

    // ==========
    // scenarios
    task automatic lat_run(input logic [31:0] w, input int lat, input logic on);
        apb(1'b1, `OTC_OFS_CTRL, w);
        ctl.pins(1'b1, 1'b0, 1'b0);
        @(posedge ck);
        skip_ck(lat - 1);
        chk("rtt_en early", 32'(rtt_en), 32'h0);
        skip_ck(1);
        chk("rtt_en on", 32'(rtt_en), 32'(on));
        chk("rtt_value", 32'(rtt_value), on ? 32'(w[11:9]) : 32'h0);
        ctl.pins(1'b0, 1'b0, 1'b0);
        @(posedge ck);
        skip_ck(lat - 1);
        chk("rtt_en hold", 32'(rtt_en), 32'(on));
        skip_ck(1);
        chk("rtt_en off", 32'(rtt_en), 32'h0);
    endtask

    // nominal code 3 so the write code always differs from it
    task automatic dyn_run(input logic [1:0] bl, input logic [1:0] wc, input logic bc4, input int add);
        apb(1'b1, `OTC_OFS_CTRL, cw(4'h5, 5'h0, 3'h3, wc, bl));
        ctl.pins(1'b1, 1'b0, 1'b0);
        @(posedge ck);
        ctl.pins(1'b1, 1'b1, bc4);
        @(posedge ck);
        ctl.pins(1'b1, 1'b0, 1'b0);
        skip_ck(2);
        chk("use_wr early", 32'(rtt_use_wr), 32'h0);
        chk("nominal", 32'(rtt_value), 32'h3);
        skip_ck(1);
        chk("use_wr on", 32'(rtt_use_wr), 32'(wc != 2'h0));
        chk("write code", 32'(rtt_value), (wc != 2'h0) ? 32'(wc) : 32'h3);
        skip_ck(add - 1);
        chk("use_wr held", 32'(rtt_use_wr), 32'(wc != 2'h0));
        skip_ck(1);
        chk("use_wr back", 32'(rtt_use_wr), 32'h0);
        chk("nominal back", 32'(rtt_value), 32'h3);
        ctl.pins(1'b0, 1'b0, 1'b0);
        @(posedge ck);
        skip_ck(3);
        chk("rtt_en off", 32'(rtt_en), 32'h0);
    endtask

    // odt low registered g+1 rises after the first high or the write
    task automatic hold_run(input logic w, input int g, input logic exp);
        apb(1'b1, `OTC_OFS_STATUS, 32'h180);
        ctl.pins(1'b1, 1'b0, 1'b0);
        @(posedge ck);
        if (w) begin
            repeat (4) ctl.pins(1'b1, 1'b0, 1'b0);
            ctl.pins(1'b1, 1'b1, 1'b0);
            @(posedge ck);
        end
        repeat (g) ctl.pins(1'b1, 1'b0, 1'b0);
        ctl.pins(1'b0, 1'b0, 1'b0);
        skip_ck(2);
        apb(1'b0, `OTC_OFS_STATUS, 32'h0);
        chk("hold flag", 32'(rd[7]), 32'(exp));
    endtask

    // ==========
    // main sequence
    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        rd_drive = 1'b0;
        err_count = 0;
        comparisons = 0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        repeat (4) @(posedge pclk);
        apb(1'b0, `OTC_OFS_CTRL, 32'h0);
        chk("ctrl reset", rd, `OTC_CTRL_RST);
        apb(1'b1, 8'h08, 32'hffffffff);
        chk("unmapped err", 32'(er), 32'h1);
        apb(1'b0, 8'h08, 32'h0);
        chk("unmapped data", rd, 32'h0);
        lat_run(cw(4'h5, 5'h0, 3'h2, 2'h1, `OTC_BL_FIX8), 3, 1'b1);
        lat_run(cw(4'h6, 5'h2, 3'h4, 2'h0, `OTC_BL_FIX8), 6, 1'b1);
        lat_run(cw(4'h8, 5'h3, 3'h1, 2'h2, `OTC_BL_FIX4), 9, 1'b1);
        lat_run(cw(4'h5, 5'h0, 3'h0, 2'h0, `OTC_BL_FIX8), 3, 1'b0);
        lat_run(cw(4'h5, 5'h0, 3'h2, 2'h1, `OTC_BL_FIX8) | 32'h20000, 3, 1'b0);
        lat_run(cw(4'h5, 5'h0, 3'h0, 2'h0, `OTC_BL_FIX8) & 32'hfffeffff, 3, 1'b0);
        dyn_run(`OTC_BL_FIX8, 2'h1, 1'b0, 6);
        dyn_run(`OTC_BL_FIX4, 2'h2, 1'b0, 4);
        dyn_run(`OTC_BL_OTF, 2'h1, 1'b1, 4);
        dyn_run(`OTC_BL_OTF, 2'h2, 1'b0, 6);
        dyn_run(`OTC_BL_FIX8, 2'h0, 1'b0, 6);
        apb(1'b1, `OTC_OFS_CTRL, cw(4'h5, 5'h0, 3'h3, 2'h1, `OTC_BL_FIX8));
        hold_run(1'b0, 1, 1'b1);
        hold_run(1'b1, 3, 1'b1);
        hold_run(1'b1, 5, 1'b0);
        ctl.pins(1'b1, 1'b0, 1'b0);
        @(posedge ck);
        skip_ck(3);
        chk("rtt_en before read", 32'(rtt_en), 32'h1);
        // the read level needs the sync pipe plus one output flop to land
        rd_drive <= 1'b1;
        repeat (7) @(posedge pclk);
        chk("rtt_en in read", 32'(rtt_en), 32'h0);
        rd_drive <= 1'b0;
        apb(1'b0, `OTC_OFS_STATUS, 32'h0);
        chk("read flag", 32'(rd[8]), 32'h1);
        ctl.pins(1'b0, 1'b0, 1'b0);
        skip_ck(5);
        close_out();
    end
endmodule
